// ---- bench/hrsb_bridge_props.sv ----
// Port checker of the hex record bridge
`timescale 1ns/10ps
module hrsb_bridge_props #(
  parameter NUM_OUT_PORTS = 16,
  parameter RX_DEPTH      = 16
) (
  // Clock and reset
  input wire                       clk,
  input wire                       nrst,
  // Bridge ports
  input wire                       rx_char_valid,
  input wire [7:0]                 rx_char,
  input wire                       tx_char_valid,
  input wire                       tx_char_ready,
  input wire [7:0]                 tx_char,
  input wire [23:0]                parallel_input,
  input wire [8*NUM_OUT_PORTS-1:0] parallel_output,
  input wire                       rx_error,
  input wire                       rx_record_ok,
  input wire [4:0]                 serial_rx_state
);
  wire       hex;
  wire       take;
  wire       colon;
  wire       tx_go;
  reg  [7:0] prev_tx;
  reg  [4:0] since_ok;
  assign hex   = (rx_char >= 8'h30 && rx_char <= 8'h39) || (rx_char >= 8'h41 && rx_char <= 8'h46);
  assign take  = rx_char_valid && hex;
  assign colon = rx_char_valid && rx_char == 8'h3A;
  assign tx_go = tx_char_valid && tx_char_ready;
  always @(posedge clk) begin
    if (!nrst) begin
      prev_tx <= 8'h00;
      since_ok <= 5'h1F;
    end else begin
      if (tx_go) begin
        prev_tx <= tx_char;
      end
      if (rx_record_ok) begin
        since_ok <= 5'h00;
      end else if (since_ok != 5'h1F) begin
        since_ok <= since_ok + 5'h01;
      end
    end
  end
  ////////////////////////////////////////////////////////////////////////////
  default clocking cb @(posedge clk); endclocking
  default disable iff (!nrst);
  a_idle_discard: assert property (serial_rx_state == 5'h01 && !colon |=>
    serial_rx_state == 5'h01) else $error("idle left without colon");
  a_colon_restart: assert property (colon |=> serial_rx_state == 5'h02)
    else $error("colon did not restart");
  a_one_per_char: assert property (!rx_char_valid |=> $stable(serial_rx_state))
    else $error("state moved without character");
  a_bad_hex_drop: assert property (serial_rx_state != 5'h01 && rx_char_valid && !hex
    && !colon |=> serial_rx_state == 5'h01 && rx_error) else $error("bad digit kept");
  a_head_steps: assert property (take && serial_rx_state[2:1] != 2'b00 |=>
    serial_rx_state == {$past(serial_rx_state[3:0]), 1'b0}) else $error("header step");
  a_nibble_alt: assert property (take && serial_rx_state == 5'h08 |=>
    serial_rx_state == 5'h10) else $error("high nibble not followed by low");
  a_record_end: assert property (rx_record_ok |-> serial_rx_state == 5'h01
    && $past(serial_rx_state) == 5'h10) else $error("record end state");
  a_out_after_ok: assert property ($changed(parallel_output) |->
    since_ok >= 5'h01 && since_ok <= 5'h10) else $error("outputs moved without good record");
  a_tx_hold: assert property (tx_char_valid && !tx_char_ready |=>
    tx_char_valid && $stable(tx_char)) else $error("character dropped while stalled");
  a_tx_count: assert property (tx_go && prev_tx == 8'h3A |-> tx_char == 8'h33)
    else $error("count digit after colon");
endmodule
bind hrsb_bridge hrsb_bridge_props #(.NUM_OUT_PORTS(NUM_OUT_PORTS), .RX_DEPTH(RX_DEPTH))
  i_props (.clk(clk), .nrst(nrst), .rx_char_valid(rx_char_valid), .rx_char(rx_char),
  .tx_char_valid(tx_char_valid), .tx_char_ready(tx_char_ready), .tx_char(tx_char),
  .parallel_input(parallel_input), .parallel_output(parallel_output),
  .rx_error(rx_error), .rx_record_ok(rx_record_ok), .serial_rx_state(serial_rx_state));

// ---- bench/hrsb_link_model.sv ----
// Far-end link model: takes sent characters with stalls, keeps the last record
`timescale 1ns/10ps
module hrsb_link_model (
  // Clock and reset
  input  wire        clk,
  input  wire        nrst,
  // Characters from the bridge
  input  wire        tx_char_valid,
  output reg         tx_char_ready,
  input  wire [7:0]  tx_char,
  // Bench control and capture
  input  wire        stall,
  output reg  [87:0] rec_line,
  output reg         rec_done
);
  reg [2:0] phase;
  reg [3:0] got;
  always @(posedge clk) begin
    if (!nrst) begin
      phase <= 3'h0;
      tx_char_ready <= 1'b0;
      got <= 4'h0;
      rec_line <= 88'h0;
      rec_done <= 1'b0;
    end else begin
      phase <= phase + 3'h1;
      tx_char_ready <= !stall && phase[2:1] != 2'b11;
      rec_done <= 1'b0;
      if (tx_char_valid && tx_char_ready) begin
        rec_line <= {rec_line[79:0], tx_char};
        got <= (tx_char == 8'h3A) ? 4'h1 : got + 4'h1;
        rec_done <= (got == 4'hA);
      end
    end
  end
endmodule

// ---- bench/tb_top.sv ----
// Self-checking bench of the hex record bridge
`timescale 1ns/10ps
module tb_top;
  reg          clk;
  reg          nrst;
  reg          rx_char_valid;
  reg  [7:0]   rx_char;
  reg  [23:0]  parallel_input;
  reg          stall;
  wire         tx_char_valid;
  wire         tx_char_ready;
  wire [7:0]   tx_char;
  wire [127:0] parallel_output;
  wire         rx_error;
  wire         rx_record_ok;
  wire [4:0]   serial_rx_state;
  wire [87:0]  rec_line;
  wire         rec_done;
  integer      err_total;
  integer      samples_checked;
  reg  [127:0] exp_po;
  reg          seen_ok;
  reg          seen_err;
  hrsb_bridge i_dut (.clk(clk), .nrst(nrst), .rx_char_valid(rx_char_valid),
    .rx_char(rx_char), .tx_char_valid(tx_char_valid), .tx_char_ready(tx_char_ready),
    .tx_char(tx_char), .parallel_input(parallel_input), .parallel_output(parallel_output),
    .rx_error(rx_error), .rx_record_ok(rx_record_ok), .serial_rx_state(serial_rx_state));
  hrsb_link_model i_link (.clk(clk), .nrst(nrst), .tx_char_valid(tx_char_valid),
    .tx_char_ready(tx_char_ready), .tx_char(tx_char), .stall(stall),
    .rec_line(rec_line), .rec_done(rec_done));
  ////////////////////////////////////////////////////////////////////////////
  task final_report;
    begin
      if (err_total == 0 && samples_checked > 0) begin
        $display("Run complete: PASS");
      end else begin
        $display("Run complete: FAIL");
      end
      $finish;
    end
  endtask
  task chk(input [127:0] got, input [127:0] exp);
    begin
      samples_checked = samples_checked + 1;
      if (got !== exp) begin
        err_total = err_total + 1;
        $display("unexpected at %0t: got %h want %h", $time, got, exp);
      end
    end
  endtask
  function [7:0] hexc(input [3:0] n);
    hexc = (n < 4'hA) ? 8'h30 + n : 8'h37 + n;
  endfunction
  task send_char(input [7:0] c);
    begin
      rx_char_valid = 1'b1;
      rx_char = c;
      @(posedge clk);
      #1;
      rx_char_valid = 1'b0;
      rx_char = ~c;
      repeat (4) begin
        seen_ok = seen_ok | rx_record_ok;
        seen_err = seen_err | rx_error;
        @(posedge clk);
        #1;
      end
    end
  endtask
  task send_byte(input [7:0] b);
    begin
      send_char(hexc(b[7:4]));
      send_char(hexc(b[3:0]));
    end
  endtask
  ////////////////////////////////////////////////////////////////////////////
  // Whole record, good or with a spoiled checksum
  task rec(input [3:0] cnt, input [3:0] st, input [7:0] base, input bad);
    reg     [7:0] sum;
    reg     [7:0] b;
    integer       k;
    begin
      seen_ok = 1'b0;
      seen_err = 1'b0;
      sum = {cnt, st};
      send_char(8'h3A);
      send_char(hexc(cnt));
      send_char(hexc(st));
      for (k = 0; k < cnt; k = k + 1) begin
        b = base + {k[3:0], k[3:0]};
        sum = sum + b;
        send_byte(b);
        if (!bad && st + k < 16) begin
          exp_po[8*(st+k) +: 8] = b;
        end
      end
      send_byte((8'h00 - sum) ^ {7'h00, bad});
      repeat (14) @(posedge clk);
      #1;
      chk(seen_ok, !bad);
      chk(seen_err, bad);
      chk(serial_rx_state, 5'h01);
      chk(parallel_output, exp_po);
    end
  endtask
  // Characters outside 0-9 and A-F inside a record, then idle noise
  task sc_bad_char;
    reg     [31:0] bads;
    integer        i;
    begin
      bads = 32'h2F404761;
      for (i = 0; i < 4; i = i + 1) begin
        seen_err = 1'b0;
        send_char(8'h3A);
        send_char(bads[8*i +: 8]);
        chk(seen_err, 1'b1);
        chk(serial_rx_state, 5'h01);
      end
      seen_err = 1'b0;
      send_char(8'h35);
      send_char(8'h58);
      chk(seen_err, 1'b0);
      chk(serial_rx_state, 5'h01);
    end
  endtask
  // Colon in mid-record restarts parsing
  task sc_restart;
    begin
      send_char(8'h3A);
      send_char(8'h32);
      send_char(8'h31);
      send_char(8'h33);
      rec(4'h2, 4'h4, 8'hC3, 1'b0);
    end
  endtask
  // Transmitted record against the sampled inputs
  task sc_tx(input [23:0] v);
    reg     [7:0] ck;
    integer       n;
    integer       t;
    begin
      parallel_input = v;
      stall = 1'b1;
      repeat (12) @(posedge clk);
      #1;
      stall = 1'b0;
      n = 0;
      for (t = 0; t < 400 && n < 3; t = t + 1) begin
        @(posedge clk);
        #1;
        if (rec_done === 1'b1) begin
          n = n + 1;
        end
      end
      if (n < 3) begin
        err_total = err_total + 1;
        final_report;
      end
      ck = 8'h00 - (8'h30 + v[7:0] + v[15:8] + v[23:16]);
      chk(rec_line, {8'h3A, 8'h33, 8'h30, hexc(v[7:4]), hexc(v[3:0]), hexc(v[15:12]),
        hexc(v[11:8]), hexc(v[23:20]), hexc(v[19:16]), hexc(ck[7:4]),
        hexc(ck[3:0])});
    end
  endtask
  // Reset in mid-run
  task sc_reset;
    begin
      nrst = 1'b0;
      repeat (2) @(posedge clk);
      #1;
      nrst = 1'b1;
      exp_po = 128'h0;
      chk(parallel_output, exp_po);
      chk(serial_rx_state, 5'h01);
    end
  endtask
  ////////////////////////////////////////////////////////////////////////////
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  initial begin
    nrst = 1'b0;
    rx_char_valid = 1'b0;
    rx_char = 8'h00;
    parallel_input = 24'h000000;
    stall = 1'b0;
    err_total = 0;
    samples_checked = 0;
    exp_po = 128'h0;
    seen_ok = 1'b0;
    seen_err = 1'b0;
    repeat (2) @(posedge clk);
    #1;
    nrst = 1'b1;
    rec(4'h3, 4'h1, 8'h09, 1'b0);
    rec(4'h2, 4'h6, 8'hF0, 1'b0);
    rec(4'h2, 4'h0, 8'hA5, 1'b1);
    rec(4'h0, 4'h5, 8'h00, 1'b0);
    rec(4'h3, 4'hE, 8'h7B, 1'b0);
    rec(4'hF, 4'h0, 8'h10, 1'b0);
    sc_bad_char;
    sc_restart;
    sc_tx(24'h9AF0E1);
    sc_tx(24'h3C5D07);
    sc_reset;
    rec(4'h1, 4'h2, 8'h5E, 1'b0);
    final_report;
  end
endmodule

// ---- pkg/hrsb_defines.vh ----
// Constants of the hex record serial/parallel bridge
// Summary of operation
// R1: An invalid hex character inside a record abandons it and returns to idle.
// R2: A colon always restarts parsing in state 1, from any state.
// R3: Receiver starts in state 0; at most one transition per received character.
// R4: Colon enters state 1, count digit state 2, start digit state 3; values stored.
// R5: State 3 takes the high nibble, state 4 the low nibble, alternating per byte.
// R6: After the checksum low nibble in state 4 return to state 0 always.
// R7: Output latches load only on a good checksum; bad records change nothing.
// R8: Hex digits are 0-9 and A-F only; anything else forces state 0.
// R9: In state 0 every character except a colon is discarded.
// R10: Transmit checksum seeds with count and start byte, adds data, sends two's complement.
// R11: First data byte goes to the start port, following bytes to higher ports.
// R12: Link is 9600 baud, 8-bit characters, both directions active.
// R13: Outgoing records report input ports 0 to 2, three ports.
// R14: Inputs resampled for every record; records sent back to back, 11 characters each.
// R15: Each record starts with a colon, then one count digit and one start digit.
// R16: Count up to 15; count zero carries no port data.
// R17: Data bytes and checksum travel as two hex characters, high nibble first.
// R18: Receiver sums count/start byte, data and checksum; zero sum means valid.
// R19: Transmit records use the same layout, uppercase hex, sent only when accepted.
// R20: A one-cycle error flag marks records dropped for checksum or bad character.
`ifndef HRSB_DEFINES_VH
`define HRSB_DEFINES_VH

`define HRSB_CHAR_COLON    8'h3A
`define HRSB_CHAR_ZERO     8'h30
`define HRSB_CHAR_NINE     8'h39
`define HRSB_CHAR_UPPER_A  8'h41
`define HRSB_CHAR_UPPER_F  8'h46
`define HRSB_ALPHA_OFFSET  8'h37
`define HRSB_CHAR_BITS     8
`define HRSB_LINK_BAUD     9600
`define HRSB_TX_PORT_COUNT 4'h3
`define HRSB_TX_START_PORT 4'h0
`define HRSB_TX_LAST_POS   4'hA
`define HRSB_TX_FIRST_DATA 4'h3
`define HRSB_RX_DEPTH      16
`define HRSB_OUT_PORTS     16
`define HRSB_OUT_RESET     8'h00

`endif

// ---- rtl/hrsb_bridge.v ----
// Hex record framer and deframer between a character link and parallel ports
`timescale 1ns/10ps
`include "hrsb_defines.vh"
module hrsb_bridge #(
  parameter NUM_OUT_PORTS = `HRSB_OUT_PORTS,
  parameter RX_DEPTH      = `HRSB_RX_DEPTH
) (
  // Clock and reset
  input  wire                       clk,
  input  wire                       nrst,
  // Received characters from the serial receiver
  input  wire                       rx_char_valid,
  input  wire [7:0]                 rx_char,
  // Characters for the serial transmitter
  output wire                       tx_char_valid,
  input  wire                       tx_char_ready,
  output wire [7:0]                 tx_char,
  // Parallel input pins, ports 0 to 2
  input  wire [23:0]                parallel_input,
  // Parallel output latches
  output reg  [8*NUM_OUT_PORTS-1:0] parallel_output,
  // Status
  output reg                        rx_error,
  output reg                        rx_record_ok,
  output reg  [4:0]                 serial_rx_state
);

  ////////////////////////////////////////////////////////////////////////////////
  // Functions

  // Hex character to {valid, nibble}
  function [4:0] hex_char_to_nibble;
    input [7:0] c;
    reg   [7:0] d;
    begin
      d = 8'h00;
      hex_char_to_nibble = 5'h00;
      if (c >= `HRSB_CHAR_ZERO && c <= `HRSB_CHAR_NINE) begin // [R8]
        d = c - `HRSB_CHAR_ZERO;
        hex_char_to_nibble = {1'b1, d[3:0]};
      end else if (c >= `HRSB_CHAR_UPPER_A && c <= `HRSB_CHAR_UPPER_F) begin // [R8]
        d = c - `HRSB_ALPHA_OFFSET;
        hex_char_to_nibble = {1'b1, d[3:0]};
      end
    end
  endfunction

  // Nibble to uppercase hex character
  function [7:0] nibble_to_hex;
    input [3:0] n;
    begin
      if (n < 4'hA) begin
        nibble_to_hex = `HRSB_CHAR_ZERO + {4'h0, n};
      end else begin
        nibble_to_hex = `HRSB_ALPHA_OFFSET + {4'h0, n}; // [R19]
      end
    end
  endfunction

  ////////////////////////////////////////////////////////////////////////////////
  // Receive states

  localparam [4:0] RX_IDLE  = 5'h01;
  localparam [4:0] RX_COUNT = 5'h02;
  localparam [4:0] RX_START = 5'h04;
  localparam [4:0] RX_HIGH  = 5'h08;
  localparam [4:0] RX_LOW   = 5'h10;

  // Transmit states
  localparam [1:0] TX_SAMPLE = 2'h1;
  localparam [1:0] TX_SEND   = 2'h2;

  ////////////////////////////////////////////////////////////////////////////////
  // Declarations

  reg  [23:0] par_meta;
  reg  [23:0] par_sync;
  reg  [3:0]  rx_count;
  reg  [3:0]  rx_start;
  reg  [3:0]  rx_idx;
  reg  [3:0]  rx_high;
  reg  [7:0]  rx_sum;
  wire [4:0]  rx_dec;
  wire        rx_hex_ok;
  wire [7:0]  rx_byte;
  wire [7:0]  rx_sum_next;
  reg         mem_wr_en;
  reg  [3:0]  mem_wr_addr;
  reg  [7:0]  mem_wr_data;
  wire [7:0]  mem_rd_data;
  reg         upd_busy;
  reg  [3:0]  output_port_index;
  reg  [3:0]  upd_count;
  reg  [3:0]  upd_start;
  reg         upd_wr;
  reg  [4:0]  upd_port;
  reg  [1:0]  tx_state;
  reg  [3:0]  tx_pos;
  reg  [31:0] tx_record_buffer;
  reg  [7:0]  next_tx_char;
  wire [3:0]  tx_rel;
  wire [7:0]  tx_sel_byte;
  wire        buf_in_ready;
  wire        tx_push;
  wire [7:0]  tx_sum;
  integer     i;

  ////////////////////////////////////////////////////////////////////////////////
  // Parallel input synchroniser

  always @(posedge clk) begin
    if (!nrst) begin
      par_meta <= 24'h000000;
      par_sync <= 24'h000000;
    end else begin
      par_meta <= parallel_input;
      par_sync <= par_meta;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Receive record parser

  assign rx_dec      = hex_char_to_nibble(rx_char); // [R8]
  assign rx_hex_ok   = rx_dec[4];
  assign rx_byte     = {rx_high, rx_dec[3:0]}; // [R17]
  assign rx_sum_next = rx_sum + rx_byte;

  always @(posedge clk) begin
    if (!nrst) begin
      serial_rx_state <= RX_IDLE; // [R3]
      rx_count        <= 4'h0;
      rx_start        <= 4'h0;
      rx_idx          <= 4'h0;
      rx_high         <= 4'h0;
      rx_sum          <= 8'h00;
      rx_error        <= 1'b0;
      rx_record_ok    <= 1'b0;
      mem_wr_en       <= 1'b0;
      mem_wr_addr     <= 4'h0;
      mem_wr_data     <= 8'h00;
    end else begin
      rx_error     <= 1'b0;
      rx_record_ok <= 1'b0;
      mem_wr_en    <= 1'b0;
      if (rx_char_valid) begin // [R3]
        if (rx_char == `HRSB_CHAR_COLON) begin
          serial_rx_state <= RX_COUNT; // [R2] [R4] [R15]
          rx_idx          <= 4'h0;
        end else begin
          case (serial_rx_state)
            RX_IDLE: begin
              serial_rx_state <= RX_IDLE; // [R9]
            end
            RX_COUNT: begin
              if (rx_hex_ok) begin
                rx_count        <= rx_dec[3:0]; // [R4] [R16]
                serial_rx_state <= RX_START;
              end else begin
                serial_rx_state <= RX_IDLE; // [R1] [R8]
                rx_error        <= 1'b1; // [R20]
              end
            end
            RX_START: begin
              if (rx_hex_ok) begin
                rx_start        <= rx_dec[3:0]; // [R4]
                rx_sum          <= {rx_count, rx_dec[3:0]}; // [R18]
                rx_idx          <= 4'h0;
                serial_rx_state <= RX_HIGH;
              end else begin
                serial_rx_state <= RX_IDLE; // [R1]
                rx_error        <= 1'b1; // [R20]
              end
            end
            RX_HIGH: begin
              if (rx_hex_ok) begin
                rx_high         <= rx_dec[3:0]; // [R5]
                serial_rx_state <= RX_LOW;
              end else begin
                serial_rx_state <= RX_IDLE; // [R1]
                rx_error        <= 1'b1; // [R20]
              end
            end
            RX_LOW: begin
              if (!rx_hex_ok) begin
                serial_rx_state <= RX_IDLE; // [R1]
                rx_error        <= 1'b1; // [R20]
              end else if (rx_idx == rx_count) begin
                serial_rx_state <= RX_IDLE; // [R6]
                if (rx_sum_next == 8'h00) begin
                  rx_record_ok <= 1'b1; // [R7] [R18]
                end else begin
                  rx_error <= 1'b1; // [R20]
                end
              end else begin
                rx_sum          <= rx_sum_next; // [R18]
                mem_wr_en       <= 1'b1;
                mem_wr_addr     <= rx_idx;
                mem_wr_data     <= rx_byte;
                rx_idx          <= rx_idx + 4'h1;
                serial_rx_state <= RX_HIGH; // [R5]
              end
            end
            default: begin
              serial_rx_state <= RX_IDLE;
            end
          endcase
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Received data bytes

  hrsb_byte_mem #(
    .WIDTH (8),
    .DEPTH (RX_DEPTH),
    .AW    (4)
  ) u_rx_record_buffer (
    .clk     (clk),
    .wr_en   (mem_wr_en),
    .wr_addr (mem_wr_addr),
    .wr_data (mem_wr_data),
    .rd_en   (upd_busy),
    .rd_addr (output_port_index),
    .rd_data (mem_rd_data)
  );

  ////////////////////////////////////////////////////////////////////////////////
  // Parallel output update

  always @(posedge clk) begin
    if (!nrst) begin
      upd_busy          <= 1'b0;
      output_port_index <= 4'h0;
      upd_count         <= 4'h0;
      upd_start         <= 4'h0;
      upd_wr            <= 1'b0;
      upd_port          <= 5'h00;
    end else begin
      upd_wr <= 1'b0;
      if (upd_busy) begin
        upd_wr            <= 1'b1;
        upd_port          <= {1'b0, upd_start} + {1'b0, output_port_index}; // [R11]
        output_port_index <= output_port_index + 4'h1;
        if (output_port_index == upd_count - 4'h1) begin
          upd_busy <= 1'b0;
        end
      end else if (rx_record_ok && rx_count != 4'h0) begin
        upd_busy          <= 1'b1; // [R7] [R16]
        output_port_index <= 4'h0;
        upd_count         <= rx_count;
        upd_start         <= rx_start;
      end
    end
  end

  always @(posedge clk) begin
    if (!nrst) begin
      parallel_output <= {NUM_OUT_PORTS{`HRSB_OUT_RESET}};
    end else if (upd_wr) begin
      for (i = 0; i < NUM_OUT_PORTS; i = i + 1) begin
        if (upd_port == i) begin
          parallel_output[8*i +: 8] <= mem_rd_data; // [R11]
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Transmit record builder

  assign tx_sum = `HRSB_TX_PORT_COUNT * 8'h10 + {4'h0, `HRSB_TX_START_PORT}
                + par_sync[7:0] + par_sync[15:8] + par_sync[23:16]; // [R10]
  assign tx_rel      = tx_pos - `HRSB_TX_FIRST_DATA;
  assign tx_sel_byte = tx_record_buffer[8*tx_rel[3:1] +: 8];
  assign tx_push     = (tx_state == TX_SEND) & buf_in_ready; // [R19]

  always @* begin
    next_tx_char = `HRSB_CHAR_COLON; // [R15]
    case (tx_pos)
      4'h0: begin
        next_tx_char = `HRSB_CHAR_COLON;
      end
      4'h1: begin
        next_tx_char = nibble_to_hex(`HRSB_TX_PORT_COUNT); // [R13]
      end
      4'h2: begin
        next_tx_char = nibble_to_hex(`HRSB_TX_START_PORT); // [R13]
      end
      default: begin
        if (!tx_rel[0]) begin
          next_tx_char = nibble_to_hex(tx_sel_byte[7:4]); // [R17]
        end else begin
          next_tx_char = nibble_to_hex(tx_sel_byte[3:0]);
        end
      end
    endcase
  end

  always @(posedge clk) begin
    if (!nrst) begin
      tx_state         <= TX_SAMPLE;
      tx_pos           <= 4'h0;
      tx_record_buffer <= 32'h00000000;
    end else begin
      case (tx_state)
        TX_SAMPLE: begin
          tx_record_buffer <= {8'h00 - tx_sum, par_sync}; // [R10] [R14]
          tx_pos           <= 4'h0;
          tx_state         <= TX_SEND;
        end
        TX_SEND: begin
          if (tx_push) begin
            tx_pos <= tx_pos + 4'h1;
            if (tx_pos == `HRSB_TX_LAST_POS) begin
              tx_state <= TX_SAMPLE; // [R14]
            end
          end
        end
        default: begin
          tx_state <= TX_SAMPLE;
        end
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Transmit character buffer

  hrsb_skid_buf #(
    .WIDTH (`HRSB_CHAR_BITS)
  ) u_tx_buf (
    .clk       (clk),
    .nrst      (nrst),
    .in_valid  (tx_state == TX_SEND),
    .in_ready  (buf_in_ready),
    .in_data   (next_tx_char),
    .out_valid (tx_char_valid),
    .out_ready (tx_char_ready), // [R19]
    .out_data  (tx_char)
  );

endmodule

// ---- rtl/hrsb_byte_mem.v ----
// Record data memory with registered read
`timescale 1ns/10ps
module hrsb_byte_mem #(
  parameter WIDTH = 8,
  parameter DEPTH = 16,
  parameter AW    = 4
) (
  // Clock
  input  wire             clk,
  // Write side
  input  wire             wr_en,
  input  wire [AW-1:0]    wr_addr,
  input  wire [WIDTH-1:0] wr_data,
  // Read side
  input  wire             rd_en,
  input  wire [AW-1:0]    rd_addr,
  output reg  [WIDTH-1:0] rd_data
);

  reg [WIDTH-1:0] mem [0:DEPTH-1];

  always @(posedge clk) begin
    if (wr_en) begin
      mem[wr_addr] <= wr_data;
    end
    if (rd_en) begin
      rd_data <= mem[rd_addr];
    end
  end

endmodule

// ---- rtl/hrsb_skid_buf.v ----
// Two-entry buffer with valid and ready on both sides
`timescale 1ns/10ps
module hrsb_skid_buf #(
  parameter WIDTH = 8
) (
  // Clock and reset
  input  wire             clk,
  input  wire             nrst,
  // Filling side
  input  wire             in_valid,
  output reg              in_ready,
  input  wire [WIDTH-1:0] in_data,
  // Draining side
  output reg              out_valid,
  input  wire             out_ready,
  output reg  [WIDTH-1:0] out_data
);

  reg [WIDTH-1:0] spare_data;
  reg             spare_valid;
  wire            push;
  wire            pop;

  assign push = in_valid & in_ready;
  assign pop  = out_valid & out_ready;

  always @(posedge clk) begin
    if (!nrst) begin
      out_valid   <= 1'b0;
      out_data    <= {WIDTH{1'b0}};
      spare_valid <= 1'b0;
      spare_data  <= {WIDTH{1'b0}};
      in_ready    <= 1'b1;
    end else begin
      if (!out_valid || pop) begin
        if (spare_valid) begin
          out_valid   <= 1'b1;
          out_data    <= spare_data;
          spare_valid <= push;
          in_ready    <= ~push;
          if (push) begin
            spare_data <= in_data;
          end
        end else begin
          out_valid <= push;
          if (push) begin
            out_data <= in_data;
          end
        end
      end else if (push) begin
        spare_valid <= 1'b1;
        spare_data  <= in_data;
        in_ready    <= 1'b0;
      end
    end
  end

endmodule
